// ==== shared/cmpc_defines.svh ====
// offsets, field positions and reset values of the comparator control block
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH
`define CMPC_OFS_MIRROR    8'h6f
`define CMPC_OFS_CTRL0_C1  8'h70
`define CMPC_OFS_CTRL1_C1  8'h71
`define CMPC_OFS_NCH_C1    8'h72
`define CMPC_OFS_PCH_C1    8'h73
`define CMPC_OFS_CTRL0_C2  8'h74
`define CMPC_OFS_CTRL1_C2  8'h75
`define CMPC_OFS_NCH_C2    8'h76
`define CMPC_OFS_PCH_C2    8'h77
`define CMPC_OFS_SYSCTL    8'h78
`define CMPC_OFS_FLAGS     8'h79
`define CMPC_BIT_EN        7
`define CMPC_BIT_OUT       6
`define CMPC_BIT_POL       4
`define CMPC_BIT_HYS       1
`define CMPC_BIT_SYNC      0
`define CMPC_BIT_RISE      1
`define CMPC_BIT_FALL      0
`define CMPC_RST_BYTE      8'h00
`define CMPC_ADC_SEL_C1    2'h1
`define CMPC_ADC_SEL_C2    2'h2
`endif

// ==== shared/cmpc_pkg.sv ====
// types shared by the comparator control block
`default_nettype none
package cmpc_pkg;
  // per comparator first control register fields
  typedef struct packed {
    logic       enable;
    logic       output_invert;
    logic       hysteresis_enable;
    logic       sync_enable;
  } cmpc_ctrl0_t;
  // per comparator second control register fields
  typedef struct packed {
    logic       rise_irq_enable;
    logic       fall_irq_enable;
  } cmpc_ctrl1_t;
  // analog front end request toward the comparator core
  typedef struct packed {
    logic       power_on;
    logic       hyst_on;
    logic [2:0] positive_channel_select;
    logic [2:0] negative_channel_select;
    logic       inputs_connected;
  } cmpc_afe_t;
  // bus slave states for the write path
  typedef enum logic [1:0] {
    CMPC_W_IDLE,
    CMPC_W_RESP
  } cmpc_wstate_t;
endpackage : cmpc_pkg
`default_nettype wire

// ==== core/cmpc_edge.sv ====
// edge detector and sticky flag for one comparator
`default_nettype none
module cmpc_edge
  import cmpc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic result,
  input  wire logic rise_en,
  input  wire logic fall_en,
  input  wire logic flag_clear,
  output logic      flag,
  output logic      rose
);
  logic prev_q;   // result of the previous instruction cycle
  logic flag_q;   // sticky edge flag
  logic rise_w;   // rising edge seen this cycle
  logic fall_w;   // falling edge seen this cycle

  // edges come from comparing this cycle with the last one
  assign rise_w = result & ~prev_q;
  assign fall_w = ~result & prev_q;

  // history register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= result;
    end
  end

  // flag: set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if ((rise_w & rise_en) | (fall_w & fall_en)) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign flag = flag_q;
  assign rose = rise_w;

  flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rise_w & rise_en) |=> flag_q) else $error("rising edge did not set flag");
  set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall_w & fall_en & flag_clear) |=> flag_q) else $error("clear beat edge");
  no_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!flag_q && $past(result) == result) |=> !flag_q)
    else $error("flag set without edge");
endmodule : cmpc_edge
`default_nettype wire

// ==== core/cmpc_sync.sv ====
// falling edge re-timing of a comparator result on the prescaled timer clock
`default_nettype none
module cmpc_sync
  import cmpc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic result,
  input  wire logic sync_enable,
  input  wire logic timer_clk_level,
  input  wire logic timer_runs,
  output logic      routed
);
  logic tclk_q;   // timer clock level of the previous cycle
  logic held_q;   // result held since the last falling edge
  logic fall_w;   // falling edge of the prescaled timer clock

  // the timer counts on its rising edge, so latching on the falling one avoids a race
  assign fall_w = tclk_q & ~timer_clk_level & timer_runs;

  // timer clock history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tclk_q <= 1'b0;
    end else begin
      tclk_q <= timer_clk_level;
    end
  end

  // latch on falling edge only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      held_q <= 1'b0;
    end else if (fall_w) begin
      held_q <= result;
    end
  end

  // sync mode picks the held copy, otherwise pass straight through
  assign routed = sync_enable ? held_q : result;

  sync_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sync_enable && !fall_w) |=> $stable(held_q)) else $error("latch moved off edge");
  sync_take_a: assert property (@(posedge clock) disable iff (!rst_n)
    fall_w |=> held_q == $past(result)) else $error("latch missed edge");
  pass_thru_a: assert property (@(posedge clock) disable iff (!rst_n)
    !sync_enable |-> routed == result) else $error("async path re-timed");
endmodule : cmpc_sync
`default_nettype wire

// ==== core/cmpc_top.sv ====
// comparator output control: registers, result latch, routing, edges and wake
`include "cmpc_defines.svh"
`default_nettype none
module cmpc_top
  import cmpc_pkg::*;
#(
  parameter int NUM_CMP  = 2,
  parameter int PORT_W   = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  // axi4-lite slave
  input  wire logic [9:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [9:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog comparator core
  input  wire logic [NUM_CMP-1:0] cmp_raw,
  output var cmpc_afe_t [NUM_CMP-1:0] afe_ctrl,
  // sync timer
  input  wire logic              timer_clk_level,
  input  wire logic              timer_on_sys_clock,
  output logic [NUM_CMP-1:0]     routed_result,
  // interrupt controller and power
  input  wire logic              sleep_mode,
  output logic [NUM_CMP-1:0]     irq_request,
  output logic                   wake_request,
  // adc
  output logic                   adc_trigger,
  // port read masking
  input  wire logic [PORT_W-1:0] port_pins,
  input  wire logic [PORT_W-1:0] analog_pin_select,
  output logic [PORT_W-1:0]      port_read_value
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  cmpc_ctrl0_t [NUM_CMP-1:0] ctrl0_q;            // first control registers
  cmpc_ctrl1_t [NUM_CMP-1:0] ctrl1_q;            // second control registers
  logic [NUM_CMP-1:0][2:0]   pch_q;              // positive channel select
  logic [NUM_CMP-1:0][2:0]   nch_q;              // negative channel select
  logic [NUM_CMP-1:0]        edge_irq_enable_q;  // per comparator irq enable
  logic                      global_irq_enable_q;// global irq enable
  logic [1:0]                adc_trigger_select_q; // adc trigger source
  logic [NUM_CMP-1:0]        result_q;           // latched polarity-adjusted result
  logic [NUM_CMP-1:0]        gated_w;            // raw result after enable gate
  logic [NUM_CMP-1:0]        adj_w;              // polarity-adjusted result
  logic [NUM_CMP-1:0]        edge_flag;          // sticky flags
  logic [NUM_CMP-1:0]        rose_w;             // rising edges of latched results
  logic [NUM_CMP-1:0]        flag_clr_w;         // software clear pulses
  logic                      adc_trig_q;         // registered adc trigger

  ////////////////////////////////////////////////////////////////////////////
  // write channel: take address and data in either order
  cmpc_wstate_t wstate_q;          // write response state
  logic         aw_held_q;         // address captured
  logic         w_held_q;          // data captured
  logic [9:0]   awaddr_q;          // captured address
  logic [7:0]   wbyte_q;           // captured low byte
  logic         wlane_q;           // low byte lane enabled
  logic         wr_go;             // perform the write this cycle

  assign s_axi_awready = (wstate_q == CMPC_W_IDLE) && !aw_held_q;
  assign s_axi_wready  = (wstate_q == CMPC_W_IDLE) && !w_held_q;
  assign wr_go         = (wstate_q == CMPC_W_IDLE) && aw_held_q && w_held_q;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_bvalid  = (wstate_q == CMPC_W_RESP);

  // capture address and data, then answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wstate_q  <= CMPC_W_IDLE;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 10'h000;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      case (wstate_q)
        CMPC_W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
          end
          if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            wstate_q  <= CMPC_W_RESP;
          end
        end
        CMPC_W_RESP: begin
          if (s_axi_bready) begin
            wstate_q <= CMPC_W_IDLE;
          end
        end
        default: begin
          wstate_q <= CMPC_W_IDLE;
        end
      endcase
    end
  end

  // register index of a byte address; indexes run past 0x3f, so more than eight address bits are needed
  function automatic logic [7:0] word_of(input logic [9:0] a);
    word_of = a[9:2];
  endfunction : word_of

  ////////////////////////////////////////////////////////////////////////////
  // register writes; byte address is four times the register index
  logic wr_ok;                      // write with low lane enabled
  assign wr_ok = wr_go && wlane_q;

  // per comparator control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl0_q <= '0;
      ctrl1_q <= '0;
      pch_q   <= '0;
      nch_q   <= '0;
    end else if (wr_ok) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (word_of(awaddr_q) == `CMPC_OFS_CTRL0_C1 + 8'(4 * i)) begin
          ctrl0_q[i].enable            <= wbyte_q[`CMPC_BIT_EN];
          ctrl0_q[i].output_invert     <= wbyte_q[`CMPC_BIT_POL];
          ctrl0_q[i].hysteresis_enable <= wbyte_q[`CMPC_BIT_HYS];
          ctrl0_q[i].sync_enable       <= wbyte_q[`CMPC_BIT_SYNC];
        end
        if (word_of(awaddr_q) == `CMPC_OFS_CTRL1_C1 + 8'(4 * i)) begin
          ctrl1_q[i].rise_irq_enable <= wbyte_q[`CMPC_BIT_RISE];
          ctrl1_q[i].fall_irq_enable <= wbyte_q[`CMPC_BIT_FALL];
        end
        if (word_of(awaddr_q) == `CMPC_OFS_NCH_C1 + 8'(4 * i)) begin
          nch_q[i] <= wbyte_q[2:0];
        end
        if (word_of(awaddr_q) == `CMPC_OFS_PCH_C1 + 8'(4 * i)) begin
          pch_q[i] <= wbyte_q[2:0];
        end
      end
    end
  end

  // system control: irq enables, global enable, adc trigger select
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_irq_enable_q    <= '0;
      global_irq_enable_q  <= 1'b0;
      adc_trigger_select_q <= 2'h0;
    end else if (wr_ok && word_of(awaddr_q) == `CMPC_OFS_SYSCTL) begin
      edge_irq_enable_q    <= wbyte_q[NUM_CMP-1:0];
      global_irq_enable_q  <= wbyte_q[7];
      adc_trigger_select_q <= wbyte_q[5:4];
    end
  end

  // writing ones to the flag register clears those flags
  assign flag_clr_w = (wr_ok && word_of(awaddr_q) == `CMPC_OFS_FLAGS) ?
                      wbyte_q[NUM_CMP-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle after the address, data from a register
  logic [7:0] rd_byte;               // decoded read byte

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    case (word_of(s_axi_araddr))
      `CMPC_OFS_MIRROR: rd_byte = {6'h00, result_q};
      `CMPC_OFS_CTRL0_C1: rd_byte = {ctrl0_q[0].enable, result_q[0], 1'b0,
                          ctrl0_q[0].output_invert, 2'b00,
                          ctrl0_q[0].hysteresis_enable, ctrl0_q[0].sync_enable};
      `CMPC_OFS_CTRL1_C1: rd_byte = {6'h00, ctrl1_q[0]};
      `CMPC_OFS_NCH_C1: rd_byte = {5'h00, nch_q[0]};
      `CMPC_OFS_PCH_C1: rd_byte = {5'h00, pch_q[0]};
      `CMPC_OFS_CTRL0_C2: rd_byte = {ctrl0_q[1].enable, result_q[1], 1'b0,
                          ctrl0_q[1].output_invert, 2'b00,
                          ctrl0_q[1].hysteresis_enable, ctrl0_q[1].sync_enable};
      `CMPC_OFS_CTRL1_C2: rd_byte = {6'h00, ctrl1_q[1]};
      `CMPC_OFS_NCH_C2: rd_byte = {5'h00, nch_q[1]};
      `CMPC_OFS_PCH_C2: rd_byte = {5'h00, pch_q[1]};
      `CMPC_OFS_SYSCTL: rd_byte = {global_irq_enable_q, 1'b0, adc_trigger_select_q,
                                   2'b00, edge_irq_enable_q};
      `CMPC_OFS_FLAGS: rd_byte = {6'h00, edge_flag};
      default: rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'h0;

  // read data register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator result path
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      gated_w[i]                      = cmp_raw[i] & ctrl0_q[i].enable;
      adj_w[i]                        = gated_w[i] ^ ctrl0_q[i].output_invert;
      afe_ctrl[i].power_on            = ctrl0_q[i].enable;
      afe_ctrl[i].hyst_on             = ctrl0_q[i].hysteresis_enable;
      afe_ctrl[i].inputs_connected    = ctrl0_q[i].enable;
      afe_ctrl[i].positive_channel_select = pch_q[i];
      afe_ctrl[i].negative_channel_select = nch_q[i];
    end
  end

  // internal result latched every instruction cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result_q <= '0;
    end else begin
      result_q <= adj_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per comparator edge logic and timer-synchronised routing
  for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
    cmpc_edge u_edge (
      .clock      (clock),
      .rst_n      (rst_n),
      .result     (result_q[g]),
      .rise_en    (ctrl1_q[g].rise_irq_enable),
      .fall_en    (ctrl1_q[g].fall_irq_enable),
      .flag_clear (flag_clr_w[g]),
      .flag       (edge_flag[g]),
      .rose       (rose_w[g])
    );
    cmpc_sync u_sync (
      .clock           (clock),
      .rst_n           (rst_n),
      .result          (adj_w[g]),
      .sync_enable     (ctrl0_q[g].sync_enable),
      .timer_clk_level (timer_clk_level),
      .timer_runs      (!(sleep_mode && timer_on_sys_clock)),
      .routed          (routed_result[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request, wake and adc trigger
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      irq_request[i] = edge_flag[i] & edge_irq_enable_q[i] & global_irq_enable_q &
                       ctrl0_q[i].enable &
                       (ctrl1_q[i].rise_irq_enable | ctrl1_q[i].fall_irq_enable);
    end
  end

  // wake needs only the per comparator irq enable
  assign wake_request = sleep_mode && |(edge_flag & edge_irq_enable_q);

  // trigger pulse on the selected comparator rising
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adc_trig_q <= 1'b0;
    end else begin
      adc_trig_q <= (adc_trigger_select_q == `CMPC_ADC_SEL_C1 && rose_w[0]) ||
                    (adc_trigger_select_q == `CMPC_ADC_SEL_C2 && rose_w[1]);
    end
  end
  assign adc_trigger = adc_trig_q;

  // analog pins read as zero
  assign port_read_value = port_pins & ~analog_pin_select;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  gate_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl0_q[0].enable |-> gated_w[0] == 1'b0) else $error("disabled result not zero");
  inputs_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl0_q[1].enable |-> !afe_ctrl[1].inputs_connected)
    else $error("inputs connected while off");
  latch_each_a: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 result_q == $past(adj_w)) else $error("result not latched");
  mirror_same_a: assert property (@(posedge clock) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && word_of(s_axi_araddr) == `CMPC_OFS_MIRROR)
    |=> s_axi_rdata[1:0] == $past(result_q)) else $error("mirror read wrong");
  irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq_request[0] |-> global_irq_enable_q && edge_irq_enable_q[0] && edge_flag[0])
    else $error("irq without enables");
  adc_trig_a: assert property (@(posedge clock) disable iff (!rst_n)
    (adc_trigger_select_q == `CMPC_ADC_SEL_C1 && rose_w[0]) |=> adc_trigger)
    else $error("adc trigger missed");
  port_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
    (port_read_value & analog_pin_select) == '0) else $error("analog pin read high");
  bresp_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("bvalid dropped");
  wr_cov_c: cover property (@(posedge clock) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
  flag_cov_c: cover property (@(posedge clock) disable iff (!rst_n) $rose(edge_flag[0]));
  adc_cov_c: cover property (@(posedge clock) disable iff (!rst_n) adc_trigger);
  wake_cov_c: cover property (@(posedge clock) disable iff (!rst_n) wake_request);
endmodule : cmpc_top
`default_nettype wire

// ==== test/cmpc_far_model.sv ====
// model of the analog comparator core and the prescaled sync timer
`default_nettype none
module cmpc_far_model
  import cmpc_pkg::*;
#(
  parameter int PRESC = 4  // clock cycles per half period of the timer clock
) (
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire cmpc_afe_t [1:0] afe_ctrl,
  input  wire logic [1:0]      vp_gt_vn,
  input  wire logic            timer_run,
  output logic [1:0]           cmp_raw,
  output logic                 timer_clk_level
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // prescaler count
  // a comparison is only made while powered with inputs connected
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_raw[i] = afe_ctrl[i].power_on & afe_ctrl[i].inputs_connected & vp_gt_vn[i];
    end
  end
  // prescaled timer clock, it stands still while the timer is stopped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 0;
      timer_clk_level <= 1'b0;
    end else if (timer_run) begin
      cnt <= (cnt == PRESC - 1) ? 0 : cnt + 1;
      if (cnt == PRESC - 1) timer_clk_level <= ~timer_clk_level;
    end
  end
endmodule : cmpc_far_model
`default_nettype wire

// ==== test/cmpc_top_test.sv ====
// register level bench of the comparator output control block
`include "cmpc_defines.svh"
`default_nettype none
module cmpc_top_test
  import cmpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, trun = 0, tsys = 0, sleep = 0;
  logic        awready, wready, bvalid, arready, rvalid, wake, adc, tclk;
  logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
  logic [7:0]  pins = 8'hff, ana = 8'h0f, pread;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0]  bresp, rresp, raw, routed, irq, vp = 0;
  cmpc_afe_t [1:0] afe;
  int n_fail = 0, checks = 0, n_adc = 0;
  cmpc_top i_cmpc_top (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_raw(raw), .afe_ctrl(afe), .timer_clk_level(tclk),
    .timer_on_sys_clock(tsys), .routed_result(routed), .sleep_mode(sleep),
    .irq_request(irq), .wake_request(wake), .adc_trigger(adc),
    .port_pins(pins), .analog_pin_select(ana), .port_read_value(pread));
  cmpc_far_model #(.PRESC(4)) i_cmpc_far_model (.clock(clock), .rst_n(rst_n),
    .afe_ctrl(afe), .vp_gt_vn(vp), .timer_run(trun), .cmp_raw(raw),
    .timer_clk_level(tclk));
  always #2.5 clock = ~clock;
  // count adc trigger pulses
  always @(posedge clock) if (adc === 1'b1) n_adc++;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one write, address and data offered together; byte address is four times the index
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [9:0] a;
    logic       ah, wh;
    a = {idx, 2'b00};
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock);
      ah = awvalid & awready;
      wh = wvalid & wready;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while ((awvalid & ~ah) | (wvalid & ~wh));
    do @(negedge clock); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'h0);
    @(posedge clock);
    bready <= 1'b0;
  endtask : wr
  // one read, compared with the expected byte
  task automatic rdr(input logic [7:0] idx, input logic [7:0] e);
    logic [9:0] a;
    logic       h;
    a = {idx, 2'b00};
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock);
      h = arready;
      @(posedge clock);
    end while (h !== 1'b1);
    arvalid <= 1'b0;
    do @(negedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    chk(32'(rresp), 32'h0);
    @(posedge clock);
    rready <= 1'b0;
    chk(rd, {24'h0, e});
  endtask : rdr
  // watchdog
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rdr(`CMPC_OFS_CTRL0_C1, 8'h00);
    rdr(`CMPC_OFS_CTRL0_C2, 8'h00);
    wr(`CMPC_OFS_CTRL0_C1, 8'hc2);
    rdr(`CMPC_OFS_CTRL0_C1, 8'h82);
    chk(32'(afe[0].hyst_on & afe[0].power_on & afe[0].inputs_connected), 32'h1);
    wr(`CMPC_OFS_PCH_C1, 8'h05);
    wr(`CMPC_OFS_NCH_C2, 8'h06);
    chk(32'({afe[0].positive_channel_select, afe[1].negative_channel_select}), 32'h2e);
    rdr(`CMPC_OFS_PCH_C1, 8'h05);
    vp <= 2'b01;
    rdr(`CMPC_OFS_CTRL0_C1, 8'hc2);
    rdr(`CMPC_OFS_MIRROR, 8'h01);
    chk(32'(routed), 32'h1);
    wr(`CMPC_OFS_CTRL0_C1, 8'h92);
    rdr(`CMPC_OFS_CTRL0_C1, 8'h92);
    wr(`CMPC_OFS_CTRL0_C1, 8'h00);
    chk(32'(afe[0].power_on | afe[0].inputs_connected), 32'h0);
    rdr(`CMPC_OFS_MIRROR, 8'h00);
    $display("test result path done");
    wr(`CMPC_OFS_SYSCTL, 8'h91);
    wr(`CMPC_OFS_CTRL1_C1, 8'h02);
    n_adc = 0;
    wr(`CMPC_OFS_CTRL0_C1, 8'h80);
    repeat (4) @(posedge clock);
    chk(32'(irq), 32'h1);
    chk(n_adc, 1);
    rdr(`CMPC_OFS_FLAGS, 8'h01);
    wr(`CMPC_OFS_FLAGS, 8'h01);
    rdr(`CMPC_OFS_FLAGS, 8'h00);
    vp <= 2'b00;
    repeat (4) @(posedge clock);
    rdr(`CMPC_OFS_FLAGS, 8'h00);
    wr(`CMPC_OFS_CTRL0_C1, 8'h00);
    wr(`CMPC_OFS_CTRL1_C1, 8'h03);
    wr(`CMPC_OFS_CTRL0_C1, 8'h10);
    rdr(`CMPC_OFS_FLAGS, 8'h01);
    chk(32'(irq), 32'h0);
    wr(`CMPC_OFS_FLAGS, 8'h01);
    sleep <= 1'b1;
    wr(`CMPC_OFS_CTRL0_C1, 8'h00);
    repeat (4) @(posedge clock);
    chk(32'(wake), 32'h1);
    sleep <= 1'b0;
    $display("test edges done");
    wr(`CMPC_OFS_CTRL0_C2, 8'h81);
    vp <= 2'b10;
    repeat (6) @(posedge clock);
    chk(32'(routed[1]), 32'h0);
    rdr(`CMPC_OFS_MIRROR, 8'h02);
    trun <= 1'b1;
    repeat (20) @(posedge clock);
    chk(32'(routed[1]), 32'h1);
    chk(32'(pread), 32'hf0);
    // asleep with the timer on the system clock the synced copy must freeze
    sleep <= 1'b1;
    tsys <= 1'b1;
    vp <= 2'b00;
    repeat (20) @(posedge clock);
    chk(32'(routed[1]), 32'h1);
    sleep <= 1'b0;
    repeat (20) @(posedge clock);
    chk(32'(routed[1]), 32'h0);
    $display("test sync and port done");
    end_sim();
  end
endmodule : cmpc_top_test
`default_nettype wire
